//--- hdl/fault_report.sv
`timescale 1ns/10ps
module fault_report #(
	parameter int NUM_BLOCKS = fault_report_pkg::NUM_BLOCKS,
	parameter int NUM_OUT = fault_report_pkg::NUM_OUT,
	parameter int MS_CYCLES = fault_report_pkg::MS_CYCLES,
	parameter int HOLDOFF_MS = fault_report_pkg::HOLDOFF_MS,
	parameter int DM1_PERIOD_MS = fault_report_pkg::DM1_PERIOD_MS
) (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic [(3+NUM_OUT)*fault_report_pkg::VAL_W-1:0] MON_VALUE,
	input wire logic CFG_WE,
	input wire logic [$clog2(NUM_BLOCKS)-1:0] CFG_BLOCK,
	input wire logic [1:0] CFG_SET,
	input wire logic [3:0] CFG_FIELD,
	input wire logic [31:0] CFG_DATA,
	input wire logic REQ_PREV_LIST,
	input wire logic REQ_CLEAR_PREV,
	input wire logic REQ_CLEAR_ACTIVE,
	input wire logic TX_READY,
	output logic TX_VALID,
	output logic TX_HEAD,
	output logic TX_LAST,
	output logic [31:0] TX_DATA,
	input wire logic [NUM_OUT-1:0] OUT_CMD,
	input wire logic [NUM_OUT-1:0] OUT_FAULT_EN,
	input wire logic [2*NUM_OUT-1:0] OUT_FAULT_RESP,
	input wire logic [NUM_OUT-1:0] OUT_FAULT_VALUE,
	input wire logic POWER_FAULT_DISABLE,
	input wire logic OVERTEMP_SHUTDOWN,
	output logic [NUM_OUT-1:0] OUT_DRIVE,
	output logic [NUM_OUT-1:0] OUT_ERR,
	output logic HOLDOFF_DONE,
	input wire logic [$clog2(NUM_BLOCKS)-1:0] STAT_BLOCK,
	output logic STAT_ACTIVE,
	output logic STAT_PREV,
	output logic STAT_FLAG,
	output logic [fault_report_pkg::OC_W-1:0] STAT_OC
);
	// ==========================================================
	// Parameters and types
	localparam int NB = NUM_BLOCKS;
	localparam int BI_W = $clog2(NUM_BLOCKS);
	localparam int NSRC = 3 + NUM_OUT;
	localparam int VW = fault_report_pkg::VAL_W;
	localparam int MS_W = $clog2(MS_CYCLES + 1);

	if (NUM_BLOCKS < 2 || NUM_BLOCKS > 16 || NUM_OUT < 1 || NUM_OUT > 13 || MS_CYCLES < 1
		|| HOLDOFF_MS < 1 || HOLDOFF_MS > 65535 || DM1_PERIOD_MS < 1 || DM1_PERIOD_MS > 65535) begin : g_chk
		$error("fault_report: parameter out of range");
	end

	typedef enum logic [1:0] {TX_IDLE, TX_HDR, TX_BODY} tx_e;

	typedef struct packed {
		logic [VW-1:0] thr;
		logic [fault_report_pkg::SPN_W-1:0] spn;
		logic [fault_report_pkg::FMI_W-1:0] fmi;
		logic gen;
		logic [fault_report_pkg::DLY_W-1:0] dly;
	} set_s;

	typedef struct packed {
		fault_report_pkg::fault_style_e style;
		logic [3:0] src;
		logic [1:0] lamp;
		logic clr;
		set_s [fault_report_pkg::NUM_SETS-1:0] sets;
		logic flag;
		logic active;
		logic prev;
		logic qual;
		logic [1:0] qset;
		logic [fault_report_pkg::DLY_W-1:0] tmr;
		logic [fault_report_pkg::OC_W-1:0] oc;
	} block_s;

	typedef struct packed {
		block_s [NB-1:0] blk;
		logic [MS_W-1:0] ms_cnt;
		logic [15:0] hold_cnt;
		logic hold_done;
		logic [15:0] per_cnt;
		logic pend_act;
		logic pend_prev;
		logic [NB-1:0] rep_prev;
		tx_e tx;
		logic [NB-1:0] tx_mask;
		logic [BI_W-1:0] tx_idx;
		logic [31:0] tx_data;
		logic [NUM_OUT-1:0] out_drive;
		logic [NUM_OUT-1:0] out_err;
		logic stat_active;
		logic stat_prev;
		logic stat_flag;
		logic [fault_report_pkg::OC_W-1:0] stat_oc;
	} state_s;

	// ==========================================================
	// Functions
	// Returns {hit, parameter set}; sets ordered low-severe .. high-severe
	function automatic logic [2:0] eval_fault(fault_report_pkg::fault_style_e style, logic [VW-1:0] v,
		set_s [fault_report_pkg::NUM_SETS-1:0] st);
		logic [2:0] r;
		r = 3'h0;
		unique case (style)
			fault_report_pkg::STYLE_MINMAX: begin
				if (v < st[0].thr) r = 3'h4;
				else if (v > st[3].thr) r = 3'h7;
			end
			fault_report_pkg::STYLE_ABS: begin
				if (v >= st[3].thr) r = 3'h7;
			end
			fault_report_pkg::STYLE_STATE: begin
				if (v >= fault_report_pkg::STATE_THRESH) r = 3'h7;
			end
			fault_report_pkg::STYLE_DOUBLE: begin
				if (v < st[0].thr) r = 3'h4;
				else if (v < st[1].thr) r = 3'h5;
				else if (v > st[3].thr) r = 3'h7;
				else if (v > st[2].thr) r = 3'h6;
			end
		endcase
		return r;
	endfunction

	// Lowest set bit index
	function automatic logic [BI_W-1:0] first_idx(logic [NB-1:0] m);
		logic [BI_W-1:0] r;
		r = '0;
		for (int j = NB - 1; j >= 0; j--) begin
			if (m[j]) r = BI_W'(j);
		end
		return r;
	endfunction

	// Four-byte code word, byte 0 in bits 7:0
	function automatic logic [31:0] make_dtc(block_s b);
		logic [31:0] r;
		set_s st;
		r = 32'h0000_0000;
		st = b.sets[b.qset];
		r[15:0] = st.spn[15:0];
		r[fault_report_pkg::DTC_FMI_LSB +: fault_report_pkg::FMI_W] = st.fmi;
		r[fault_report_pkg::DTC_SPN_HI_LSB +: 3] = st.spn[18:16];
		r[fault_report_pkg::DTC_OC_LSB +: fault_report_pkg::OC_W] = b.oc;
		r[fault_report_pkg::DTC_CM_BIT] = fault_report_pkg::CM_VALUE;
		return r;
	endfunction

	// Reset image of the whole state
	function automatic state_s init_state();
		state_s r;
		r = '0;
		for (int i = 0; i < NB; i++) begin
			r.blk[i].style = fault_report_pkg::STYLE_MINMAX;
			r.blk[i].src = (i < 3) ? 4'(i) : fault_report_pkg::SRC_SUPPLY;
			r.blk[i].lamp = fault_report_pkg::DEF_LAMP;
			for (int k = 0; k < fault_report_pkg::NUM_SETS; k++) begin
				r.blk[i].sets[k].thr = (k < 2) ? fault_report_pkg::DEF_THRESH_LO : fault_report_pkg::DEF_THRESH_HI;
				r.blk[i].sets[k].fmi = fault_report_pkg::DEF_FMI[k*fault_report_pkg::FMI_W +: fault_report_pkg::FMI_W];
				r.blk[i].sets[k].gen = 1'b1;
				r.blk[i].sets[k].dly = fault_report_pkg::DEF_DELAY;
			end
		end
		r.blk[2].style = fault_report_pkg::STYLE_STATE;
		r.tx = TX_IDLE;
		return r;
	endfunction

	localparam state_s RESET_STATE = init_state();

	state_s s;
	state_s next_s;
	logic tick;
	logic qualify;
	logic [VW-1:0] val;
	logic [2:0] hit;
	logic [NB-1:0] rep;
	logic [NB-1:0] plist;
	logic [NB-1:0] mask;
	logic [NB-1:0] rest;
	logic [7:0] lamp;
	logic [7:0] cnt;
	logic err_pwr;
	logic err_tmp;
	logic shut;
	logic [NUM_OUT-1:0] oerr;

	// ==========================================================
	// Next-state logic
	always_comb begin
		next_s = s;
		qualify = 1'b0;
		val = '0;
		hit = 3'h0;
		rep = '0;
		plist = '0;
		mask = '0;
		rest = '0;
		lamp = 8'h00;
		cnt = 8'h00;
		err_pwr = 1'b0;
		err_tmp = 1'b0;
		oerr = '0;
		// Millisecond time base and power-up hold-off
		tick = (s.ms_cnt == MS_W'(MS_CYCLES - 1));
		next_s.ms_cnt = tick ? '0 : s.ms_cnt + MS_W'(1);
		if (tick && !s.hold_done) begin
			next_s.hold_cnt = s.hold_cnt + 16'h0001;
			next_s.hold_done = (s.hold_cnt == 16'(HOLDOFF_MS - 1));
		end
		// Per-block qualification and code state
		for (int i = 0; i < NB; i++) begin
			val = (s.blk[i].src < 4'(NSRC)) ? MON_VALUE[VW*int'(s.blk[i].src) +: VW] : '0;
			hit = eval_fault(s.blk[i].style, val, s.blk[i].sets);
			qualify = 1'b0;
			if (!hit[2]) begin
				next_s.blk[i].flag = 1'b0;
				next_s.blk[i].qual = 1'b0;
				if (s.blk[i].active && !s.blk[i].clr) begin
					next_s.blk[i].active = 1'b0;
					next_s.blk[i].prev = 1'b1;
				end
			end else if (!s.blk[i].flag) begin
				if (!s.blk[i].qual || hit[1:0] != s.blk[i].qset) begin
					next_s.blk[i].qual = 1'b1;
					next_s.blk[i].qset = hit[1:0];
					next_s.blk[i].tmr = s.blk[i].sets[hit[1:0]].dly;
				end else if (s.blk[i].tmr == '0) begin
					qualify = 1'b1;
					next_s.blk[i].flag = 1'b1;
					next_s.blk[i].qual = 1'b0;
					if (s.blk[i].sets[s.blk[i].qset].gen) begin
						next_s.blk[i].active = 1'b1;
						if (s.blk[i].oc != '1) next_s.blk[i].oc = s.blk[i].oc + 7'h01;
					end
				end else if (tick) begin
					next_s.blk[i].tmr = s.blk[i].tmr - 16'h0001;
				end
			end
			// Requested clears; a code qualifying this cycle survives
			if (REQ_CLEAR_ACTIVE && !qualify) begin
				next_s.blk[i].active = 1'b0;
				next_s.blk[i].flag = 1'b0;
				next_s.blk[i].qual = 1'b0;
			end
			if (REQ_CLEAR_PREV && s.blk[i].prev && !next_s.blk[i].active) begin
				next_s.blk[i].prev = 1'b0;
				next_s.blk[i].oc = '0;
			end
			// Configuration writes
			if (CFG_WE && CFG_BLOCK == BI_W'(i)) begin
				case (CFG_FIELD)
					fault_report_pkg::FLD_STYLE: next_s.blk[i].style = fault_report_pkg::fault_style_e'(CFG_DATA[1:0]);
					fault_report_pkg::FLD_SOURCE: next_s.blk[i].src = CFG_DATA[3:0];
					fault_report_pkg::FLD_LAMP: next_s.blk[i].lamp = CFG_DATA[1:0];
					fault_report_pkg::FLD_CLEAR_REQ: next_s.blk[i].clr = CFG_DATA[0];
					fault_report_pkg::FLD_THRESH: next_s.blk[i].sets[CFG_SET].thr = CFG_DATA[VW-1:0];
					fault_report_pkg::FLD_SPN: begin
						next_s.blk[i].sets[CFG_SET].spn = CFG_DATA[fault_report_pkg::SPN_W-1:0];
						if (CFG_DATA[fault_report_pkg::SPN_W-1:0] != s.blk[i].sets[CFG_SET].spn)
							next_s.blk[i].oc = '0;
					end
					fault_report_pkg::FLD_FMI: begin
						if (CFG_DATA[fault_report_pkg::FMI_W-1:0] <= fault_report_pkg::FMI_MAX
							&& CFG_DATA[31:fault_report_pkg::FMI_W] == '0)
							next_s.blk[i].sets[CFG_SET].fmi = CFG_DATA[fault_report_pkg::FMI_W-1:0];
					end
					fault_report_pkg::FLD_GEN: next_s.blk[i].sets[CFG_SET].gen = CFG_DATA[0];
					fault_report_pkg::FLD_DELAY: next_s.blk[i].sets[CFG_SET].dly = CFG_DATA[15:0];
					fault_report_pkg::FLD_OC: next_s.blk[i].oc = CFG_DATA[fault_report_pkg::OC_W-1:0];
					default: ;
				endcase
			end
			// Reportable lists; zero parameter number is never sent
			rep[i] = s.blk[i].active && s.blk[i].sets[s.blk[i].qset].spn != '0;
			plist[i] = s.blk[i].prev && !s.blk[i].active && s.blk[i].sets[s.blk[i].qset].spn != '0;
			// Internal error flags
			if (s.blk[i].flag && s.blk[i].src == fault_report_pkg::SRC_SUPPLY) err_pwr = 1'b1;
			if (s.blk[i].flag && s.blk[i].src == fault_report_pkg::SRC_TEMP) err_tmp = 1'b1;
			for (int k = 0; k < NUM_OUT; k++) begin
				if (s.blk[i].flag && s.blk[i].src == fault_report_pkg::SRC_OUT0 + 4'(k)) oerr[k] = 1'b1;
			end
		end
		// Message triggers: new code, last code gone, period
		next_s.rep_prev = rep;
		if (s.hold_done && tick) begin
			next_s.per_cnt = (s.per_cnt == 16'(DM1_PERIOD_MS - 1)) ? 16'h0000 : s.per_cnt + 16'h0001;
		end
		if (s.tx == TX_IDLE && s.hold_done && s.pend_act) next_s.pend_act = 1'b0;
		else if (s.tx == TX_IDLE && s.pend_prev && !(s.hold_done && s.pend_act)) next_s.pend_prev = 1'b0;
		if (|(rep & ~s.rep_prev)) next_s.pend_act = 1'b1;
		if (|s.rep_prev && ~|rep) next_s.pend_act = 1'b1;
		if (s.hold_done && tick && s.per_cnt == 16'(DM1_PERIOD_MS - 1)) next_s.pend_act = 1'b1;
		if (REQ_PREV_LIST) next_s.pend_prev = 1'b1;
		// Transmit engine
		mask = (s.hold_done && s.pend_act) ? rep : plist;
		for (int i = 0; i < NB; i++) begin
			if (mask[i]) begin
				lamp = lamp | (8'h01 << {s.blk[i].lamp, 1'b0});
				cnt = cnt + 8'h01;
			end
		end
		rest = s.tx_mask & ~(NB'(1) << s.tx_idx);
		unique case (s.tx)
			TX_IDLE: begin
				if ((s.hold_done && s.pend_act) || s.pend_prev) begin
					next_s.tx = TX_HDR;
					next_s.tx_mask = mask;
					next_s.tx_data = 32'h0000_0000;
					next_s.tx_data[7:0] = lamp;
					next_s.tx_data[fault_report_pkg::HDR_COUNT_LSB +: 8] = cnt;
					next_s.tx_data[fault_report_pkg::HDR_MULTI_BIT] = (cnt > 8'h01);
					next_s.tx_data[fault_report_pkg::HDR_PREV_BIT] = !(s.hold_done && s.pend_act);
				end
			end
			TX_HDR: begin
				if (TX_READY) begin
					if (s.tx_mask == '0) begin
						next_s.tx = TX_IDLE;
					end else begin
						next_s.tx = TX_BODY;
						next_s.tx_idx = first_idx(s.tx_mask);
						next_s.tx_data = make_dtc(s.blk[first_idx(s.tx_mask)]);
					end
				end
			end
			TX_BODY: begin
				if (TX_READY) begin
					next_s.tx_mask = rest;
					if (rest == '0) begin
						next_s.tx = TX_IDLE;
					end else begin
						next_s.tx_idx = first_idx(rest);
						next_s.tx_data = make_dtc(s.blk[first_idx(rest)]);
					end
				end
			end
			default: next_s.tx = TX_IDLE;
		endcase
		// Output fault response and shutdown
		shut = (POWER_FAULT_DISABLE && err_pwr) || (OVERTEMP_SHUTDOWN && err_tmp);
		next_s.out_err = oerr;
		for (int k = 0; k < NUM_OUT; k++) begin
			if (shut) begin
				next_s.out_drive[k] = 1'b0;
			end else if (oerr[k] && OUT_FAULT_EN[k]) begin
				unique case (OUT_FAULT_RESP[2*k +: 2])
					fault_report_pkg::RESP_OFF: next_s.out_drive[k] = 1'b0;
					fault_report_pkg::RESP_VALUE: next_s.out_drive[k] = OUT_FAULT_VALUE[k];
					fault_report_pkg::RESP_HOLD: next_s.out_drive[k] = s.out_drive[k];
					default: next_s.out_drive[k] = 1'b0;
				endcase
			end else begin
				next_s.out_drive[k] = OUT_CMD[k];
			end
		end
		// Status snapshot
		next_s.stat_active = s.blk[STAT_BLOCK].active;
		next_s.stat_prev = s.blk[STAT_BLOCK].prev;
		next_s.stat_flag = s.blk[STAT_BLOCK].flag;
		next_s.stat_oc = s.blk[STAT_BLOCK].oc;
	end

	// ==========================================================
	// State register
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) s <= RESET_STATE;
		else s <= next_s;
	end

	// Port drive
	assign TX_VALID = (s.tx != TX_IDLE);
	assign TX_HEAD = (s.tx == TX_HDR);
	assign TX_LAST = (s.tx == TX_HDR) ? (s.tx_mask == '0) : ((s.tx == TX_BODY) && (rest == '0));
	assign TX_DATA = s.tx_data;
	assign OUT_DRIVE = s.out_drive;
	assign OUT_ERR = s.out_err;
	assign HOLDOFF_DONE = s.hold_done;
	assign STAT_ACTIVE = s.stat_active;
	assign STAT_PREV = s.stat_prev;
	assign STAT_FLAG = s.stat_flag;
	assign STAT_OC = s.stat_oc;
endmodule // fault_report

//--- hdl/fault_report_pkg.sv
package fault_report_pkg;
	// ==========================================================
	// Sizes
	localparam int NUM_BLOCKS = 16;
	localparam int NUM_SETS = 4;
	localparam int NUM_OUT = 9;
	localparam int VAL_W = 16;
	localparam int SPN_W = 19;
	localparam int FMI_W = 5;
	localparam int OC_W = 7;
	localparam int DLY_W = 16;
	localparam logic [FMI_W-1:0] FMI_MAX = 5'h15;
	localparam logic [VAL_W-1:0] STATE_THRESH = 16'h0001;
	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int MS_NS = 1000000;
	localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
	localparam int HOLDOFF_MS = 5000;
	localparam int DM1_PERIOD_MS = 1000;
	// ==========================================================
	// Codes
	typedef enum logic [1:0] {STYLE_MINMAX, STYLE_ABS, STYLE_STATE, STYLE_DOUBLE} fault_style_e;
	localparam logic [3:0] SRC_SUPPLY = 4'h0;
	localparam logic [3:0] SRC_TEMP = 4'h1;
	localparam logic [3:0] SRC_TIMEOUT = 4'h2;
	localparam logic [3:0] SRC_OUT0 = 4'h3;
	localparam logic [3:0] FLD_STYLE = 4'h0;
	localparam logic [3:0] FLD_SOURCE = 4'h1;
	localparam logic [3:0] FLD_LAMP = 4'h2;
	localparam logic [3:0] FLD_CLEAR_REQ = 4'h3;
	localparam logic [3:0] FLD_THRESH = 4'h4;
	localparam logic [3:0] FLD_SPN = 4'h5;
	localparam logic [3:0] FLD_FMI = 4'h6;
	localparam logic [3:0] FLD_GEN = 4'h7;
	localparam logic [3:0] FLD_DELAY = 4'h8;
	localparam logic [3:0] FLD_OC = 4'h9;
	localparam logic [1:0] RESP_OFF = 2'h0;
	localparam logic [1:0] RESP_VALUE = 2'h1;
	localparam logic [1:0] RESP_HOLD = 2'h2;
	// ==========================================================
	// Word layouts
	localparam int DTC_FMI_LSB = 16;
	localparam int DTC_SPN_HI_LSB = 21;
	localparam int DTC_OC_LSB = 24;
	localparam int DTC_CM_BIT = 31;
	localparam logic CM_VALUE = 1'b0;
	localparam int HDR_COUNT_LSB = 8;
	localparam int HDR_MULTI_BIT = 16;
	localparam int HDR_PREV_BIT = 17;
	// ==========================================================
	// Reset values
	localparam logic [1:0] DEF_LAMP = 2'h1;
	localparam logic [VAL_W-1:0] DEF_THRESH_LO = 16'h0000;
	localparam logic [VAL_W-1:0] DEF_THRESH_HI = 16'hFFFF;
	localparam logic [4*FMI_W-1:0] DEF_FMI = {5'h00, 5'h10, 5'h12, 5'h01};
	localparam logic [DLY_W-1:0] DEF_DELAY = 16'h0000;
endpackage

//--- tb/fault_report_sva.sv
`timescale 1ns/10ps
// ==========================================================
// Port checker
module fault_report_sva #(
	parameter int NUM_OUT = 9,
	parameter int MS_CYCLES = 10,
	parameter int HOLDOFF_MS = 3
) (
	input wire logic CORE_CLK,
	input wire logic ARST_N,
	input wire logic TX_READY,
	input wire logic TX_VALID,
	input wire logic TX_HEAD,
	input wire logic TX_LAST,
	input wire logic [31:0] TX_DATA,
	input wire logic [NUM_OUT-1:0] OUT_CMD,
	input wire logic [NUM_OUT-1:0] OUT_FAULT_EN,
	input wire logic POWER_FAULT_DISABLE,
	input wire logic OVERTEMP_SHUTDOWN,
	input wire logic [NUM_OUT-1:0] OUT_DRIVE,
	input wire logic HOLDOFF_DONE
);
	int cyc;
	default clocking dc @(posedge CORE_CLK);
	endclocking
	default disable iff (!ARST_N);
	// Cycles since reset release, saturating
	always_ff @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cyc <= 0;
		end else if (cyc < 1000000) begin
			cyc <= cyc + 1;
		end
	end
	// Beat handshake steps
	sequence beat_stall;
		TX_VALID && !TX_READY;
	endsequence
	sequence beat_same;
		TX_VALID && $stable(TX_DATA) && $stable(TX_HEAD) && $stable(TX_LAST);
	endsequence
	chk_holdoff_quiet: assert property (!HOLDOFF_DONE && TX_VALID && TX_HEAD |-> TX_DATA[17])
		else $error("active list sent during hold-off");
	chk_holdoff_early: assert property (cyc < HOLDOFF_MS * MS_CYCLES - 1 |-> !HOLDOFF_DONE)
		else $error("hold-off ended early");
	chk_holdoff_late: assert property (cyc > HOLDOFF_MS * MS_CYCLES + 3 |-> HOLDOFF_DONE)
		else $error("hold-off ended late");
	chk_beat_hold: assert property (beat_stall |=> beat_same)
		else $error("beat changed while stalled");
	chk_cm_zero: assert property (TX_VALID && !TX_HEAD |-> !TX_DATA[31])
		else $error("conversion bit set");
	chk_multi_mark: assert property (TX_VALID && TX_HEAD |-> TX_DATA[16] == (TX_DATA[15:8] > 8'h01))
		else $error("multipacket mark wrong");
	chk_empty_last: assert property (TX_VALID && TX_HEAD && TX_DATA[15:8] == 8'h00 |-> TX_LAST)
		else $error("empty list not single beat");
	chk_fmi_range: assert property (TX_VALID && !TX_HEAD |-> TX_DATA[20:16] <= 5'h15)
		else $error("failure mode out of range");
	chk_count_max: assert property (TX_VALID && TX_HEAD |-> TX_DATA[15:8] <= 8'h10)
		else $error("code count above block count");
	chk_msg_end: assert property (TX_VALID && TX_READY && TX_LAST |=> !TX_VALID || TX_HEAD)
		else $error("beat after last");
	chk_drive_cmd: assert property ($past(ARST_N) && !$past(POWER_FAULT_DISABLE) && !$past(OVERTEMP_SHUTDOWN)
		|-> (OUT_DRIVE & ~$past(OUT_FAULT_EN)) == ($past(OUT_CMD) & ~$past(OUT_FAULT_EN)))
		else $error("drive not following command");
endmodule // fault_report_sva
bind fault_report fault_report_sva #(.NUM_OUT(NUM_OUT), .MS_CYCLES(MS_CYCLES), .HOLDOFF_MS(HOLDOFF_MS))
	fault_report_sva_inst (.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .TX_READY(TX_READY), .TX_VALID(TX_VALID),
	.TX_HEAD(TX_HEAD), .TX_LAST(TX_LAST), .TX_DATA(TX_DATA), .OUT_CMD(OUT_CMD), .OUT_FAULT_EN(OUT_FAULT_EN),
	.POWER_FAULT_DISABLE(POWER_FAULT_DISABLE), .OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN),
	.OUT_DRIVE(OUT_DRIVE), .HOLDOFF_DONE(HOLDOFF_DONE));

//--- tb/fault_report_tb_top.sv
`timescale 1ns/10ps
// ==========================================================
// Bench top
module fault_report_tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [191:0] mon = 192'h200;
	logic cfg_we = 1'b0;
	logic [3:0] cfg_blk = 4'h0;
	logic [1:0] cfg_set = 2'h0;
	logic [3:0] cfg_fld = 4'h0;
	logic [31:0] cfg_dat = 32'h0;
	logic [2:0] req = 3'h0;
	logic [8:0] cmd = 9'h000;
	logic [8:0] fen = 9'h000;
	logic [17:0] fresp = 18'h00000;
	logic [8:0] fval = 9'h000;
	logic pwr = 1'b0;
	logic ovt = 1'b0;
	logic [3:0] sblk = 4'h0;
	logic slow = 1'b0;
	logic ready, valid, head, last, hdone, s_act, s_prev, s_flag;
	logic [31:0] data, hdr, code;
	logic [8:0] drive, oerr;
	logic [6:0] s_oc;
	int msgs, errors, comparisons, cyc;
	localparam logic [15:0] TAB [8] = '{16'h2000, 16'h2011, 16'h13F0, 16'h1401,
		16'h3250, 16'h3151, 16'h0250, 16'h0051};
	fault_report #(.MS_CYCLES(10), .HOLDOFF_MS(3), .DM1_PERIOD_MS(5)) fault_report_inst (
		.CORE_CLK(clk), .ARST_N(rst_n), .MON_VALUE(mon), .CFG_WE(cfg_we), .CFG_BLOCK(cfg_blk),
		.CFG_SET(cfg_set), .CFG_FIELD(cfg_fld), .CFG_DATA(cfg_dat), .REQ_PREV_LIST(req[0]),
		.REQ_CLEAR_PREV(req[1]), .REQ_CLEAR_ACTIVE(req[2]), .TX_READY(ready), .TX_VALID(valid),
		.TX_HEAD(head), .TX_LAST(last), .TX_DATA(data), .OUT_CMD(cmd), .OUT_FAULT_EN(fen),
		.OUT_FAULT_RESP(fresp), .OUT_FAULT_VALUE(fval), .POWER_FAULT_DISABLE(pwr),
		.OVERTEMP_SHUTDOWN(ovt), .OUT_DRIVE(drive), .OUT_ERR(oerr), .HOLDOFF_DONE(hdone),
		.STAT_BLOCK(sblk), .STAT_ACTIVE(s_act), .STAT_PREV(s_prev), .STAT_FLAG(s_flag), .STAT_OC(s_oc));
	tx_sink tx_sink_inst (.clk(clk), .rst_n(rst_n), .slow(slow), .valid(valid), .head(head),
		.last(last), .data(data), .ready(ready), .hdr(hdr), .code(code), .msgs(msgs));
	// Clock and cycle ceiling
	initial begin
		forever #5 clk = !clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			end_of_test();
		end
	end
	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	// One config write, then a quiet cycle
	task automatic cfg(input int b, input int s, input logic [3:0] f, input logic [31:0] d);
		cfg_we = 1'b1;
		cfg_blk = 4'(b);
		cfg_set = 2'(s);
		cfg_fld = f;
		cfg_dat = d;
		@(negedge clk);
		cfg_we = 1'b0;
		@(negedge clk);
	endtask
	task automatic pulse(input int k);
		req[k] = 1'b1;
		@(negedge clk);
		req[k] = 1'b0;
		@(negedge clk);
	endtask
	task automatic wait_msg(input int n);
		int m;
		m = msgs;
		repeat (n) begin
			if (msgs == m) @(negedge clk);
		end
		chk("message", 32'(msgs != m), 32'h1);
	endtask
	task automatic stat(input int b);
		sblk = 4'(b);
		repeat (3) @(negedge clk);
	endtask
	task automatic end_of_test();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		chk("holdoff", 32'(hdone), 32'h0);
		// Requested previous list may go out during hold-off
		pulse(0);
		wait_msg(4);
		chk("early_prev", hdr, 32'h20000);
		chk("holdoff_prev", 32'(hdone), 32'h0);
		cfg(0, 0, fault_report_pkg::FLD_SPN, 32'h123);
		cfg(0, 0, fault_report_pkg::FLD_THRESH, 32'h100);
		cfg(1, 3, fault_report_pkg::FLD_SPN, 32'h45);
		cfg(1, 3, fault_report_pkg::FLD_THRESH, 32'h10);
		wait_msg(120);
		chk("empty_hdr", hdr, 32'h0);
		mon[15:0] = 16'h0050;
		wait_msg(12);
		chk("hdr1", hdr, 32'h104);
		chk("code1", code, 32'h01010123);
		stat(0);
		chk("oc1", {s_act, 24'h0, s_oc}, 32'h80000001);
		slow = 1'b1;
		mon[31:16] = 16'h0020;
		wait_msg(16);
		chk("hdr2", hdr, 32'h10204);
		chk("code_first", code, 32'h01010123);
		cmd = 9'h1FF;
		for (int k = 1; k < 3; k++) begin
			{pwr, ovt} = 2'(k);
			repeat (3) @(negedge clk);
			chk("shutdown", 32'(drive), 32'h0);
		end
		{pwr, ovt} = 2'h0;
		cfg(3, 3, fault_report_pkg::FLD_THRESH, 32'h10);
		cfg(3, 0, fault_report_pkg::FLD_SOURCE, 32'(fault_report_pkg::SRC_OUT0));
		fen = 9'h001;
		fval = 9'h001;
		mon[63:48] = 16'h0020;
		// Off, fault value, then hold with the fault value lowered
		for (int r = 0; r < 3; r++) begin
			fresp[1:0] = (r == 0) ? fault_report_pkg::RESP_OFF
				: (r == 1) ? fault_report_pkg::RESP_VALUE : fault_report_pkg::RESP_HOLD;
			fval = (r == 2) ? 9'h000 : 9'h001;
			repeat (5) @(negedge clk);
			chk("out_err", 32'(oerr), 32'h1);
			chk("out_drive", 32'(drive), (r == 0) ? 32'h1FE : 32'h1FF);
		end
		mon[63:48] = 16'h0000;
		mon[15:0] = 16'h0200;
		stat(0);
		chk("prev0", {s_act, s_prev}, 32'h1);
		mon[31:16] = 16'h0000;
		wait_msg(16);
		chk("none_left", hdr, 32'h0);
		{pwr, ovt} = 2'h3;
		repeat (3) @(negedge clk);
		chk("no_shutdown", 32'(drive), 32'h1FF);
		{pwr, ovt} = 2'h0;
		pulse(0);
		wait_msg(16);
		chk("prev_list", 32'(hdr[17:8]), 32'h302);
		pulse(1);
		stat(0);
		chk("prev_clr", {s_prev, 24'h0, s_oc}, 32'h0);
		cfg(0, 0, fault_report_pkg::FLD_FMI, 32'h16);
		cfg(0, 0, fault_report_pkg::FLD_CLEAR_REQ, 32'h1);
		mon[15:0] = 16'h0050;
		wait_msg(16);
		chk("fmi_kept", code, 32'h01010123);
		mon[15:0] = 16'h0200;
		stat(0);
		chk("held", {s_act, s_flag}, 32'h2);
		pulse(2);
		stat(0);
		chk("cleared", {s_act, 24'h0, s_oc}, 32'h1);
		cfg(0, 0, fault_report_pkg::FLD_SPN, 32'h124);
		stat(0);
		chk("oc_zero", 32'(s_oc), 32'h0);
		cfg(0, 0, fault_report_pkg::FLD_OC, 32'h7F);
		mon[15:0] = 16'h0050;
		stat(0);
		chk("oc_sat", 32'(s_oc), 32'h7F);
		mon[15:0] = 16'h0200;
		pulse(2);
		cfg(4, 0, fault_report_pkg::FLD_SOURCE, 32'(fault_report_pkg::SRC_TIMEOUT));
		for (int s = 0; s < 4; s++) begin
			cfg(4, s, fault_report_pkg::FLD_THRESH, 32'(16 * (s + 1)));
		end
		for (int i = 0; i < 8; i++) begin
			cfg(4, 0, fault_report_pkg::FLD_STYLE, 32'(TAB[i][13:12]));
			mon[47:32] = {8'h00, TAB[i][11:4]};
			stat(4);
			chk("style_flag", 32'(s_flag), 32'(TAB[i][0]));
		end
		// Double style below both low thresholds: most severe set is reported
		mon[47:32] = 16'h0025;
		cfg(4, 0, fault_report_pkg::FLD_SPN, 32'h300);
		cfg(4, 1, fault_report_pkg::FLD_SPN, 32'h301);
		cfg(4, 0, fault_report_pkg::FLD_STYLE, 32'(fault_report_pkg::STYLE_DOUBLE));
		mon[47:32] = 16'h0005;
		repeat (16) @(negedge clk);
		chk("severe_set", code, 32'h01010300);
		end_of_test();
	end
endmodule // fault_report_tb_top

//--- tb/tx_sink.sv
`timescale 1ns/10ps
// ==========================================================
// Network node taking diagnostic messages
module tx_sink (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic slow,
	input wire logic valid,
	input wire logic head,
	input wire logic last,
	input wire logic [31:0] data,
	output logic ready,
	output logic [31:0] hdr,
	output logic [31:0] code,
	output int msgs
);
	logic first;
	// Take beats; slow mode accepts every other cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ready <= 1'b0;
			hdr <= '0;
			code <= '0;
			msgs <= 0;
			first <= 1'b0;
		end else begin
			ready <= slow ? !ready : 1'b1;
			if (valid && ready) begin
				first <= head;
				if (head) hdr <= data;
				if (first && !head) code <= data;
				if (last) msgs <= msgs + 1;
			end
		end
	end
endmodule // tx_sink
